// ---- hdl/acmp_control.sv ----
// acmp_control: APB registers, input steering, filter, edge interrupt and pin buffer control
// assumes the analog comparator drives raw_compare from outside the clock domain
// Operation
// - result is high when plus terminal exceeds minus terminal, low otherwise
// - with power-on field clear, comparator result is held low
// - input exchange swaps the terminals and inverts the result
// - reference code 00 off, 01 quarter supply, 10 half supply
// - filter enable passes result through the filter, else unfiltered
// - reference generator level follows the reference-level field
// - generated reference goes to the terminal chosen by reference select
// - each set port-disable bit turns off that pin's input and output buffers
// - pins selected as comparator inputs get buffers disabled automatically
// - one flag and one interrupt vector serve all comparator events; code adds irq_status edge bits masked onto a second request, irq_out
// - flag is set on rising or falling result edge per edge select
// - request only while flag, local enable and global enable are set; irq_out ignores them and follows irq_status masked by irq_mask
// - flag clears when serviced, and software writes may clear it
// - result is offered to the timer capture input
// - three read-write byte registers at 059h, 05Ah, 05Bh, reset at power-on
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module acmp_control
	import acmp_pkg::*;
(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [ACMP_ADDR_W-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  raw_compare,
	input  wire logic                  global_irq_enable,
	input  wire logic                  irq_serviced,
	output logic                       comparator_power_on,
	output logic                       input_exchange,
	output acmp_ref_ctl_t              ref_ctl,
	output logic [ACMP_PINS-1:0]       pin_buffer_disable,
	output logic                       compare_result,
	output logic                       timer_capture_input,
	output logic                       compare_irq,
	output logic                       irq_out
);
	logic [7:0] comparator_control_one;
	logic [7:0] comparator_control_two;
	logic [7:0] analog_port_disable;
	logic [7:0] irq_status;
	logic [7:0] irq_mask;
	logic       sync_a;
	logic       sync_b;
	logic [ACMP_FILT_LEN-1:0] filt_hist;
	logic       filt_state;
	logic       result_q;
	logic       result_prev;
	logic       next_result;
	logic       raw_oriented;
	logic       edge_hit;
	logic [1:0] ref_level;
	logic [4:0] input_pin_select;
	logic [9:0] word_idx;
	logic       wr_en;
	logic       rd_en;
	logic       addr_ok;
	logic       byte_aligned;

	assign pready       = 1'b1;
	assign byte_aligned = (paddr[1:0] == 2'b00);
	assign word_idx     = paddr[ACMP_ADDR_W-1:2];
	assign addr_ok      = byte_aligned && ((word_idx == {2'b00, ACMP_IDX_CTL1})
		|| (word_idx == {2'b00, ACMP_IDX_CTL2}) || (word_idx == {2'b00, ACMP_IDX_PDIS})
		|| (word_idx == {2'b00, ACMP_IDX_IRQ_STAT}) || (word_idx == {2'b00, ACMP_IDX_IRQ_MASK}));
	assign wr_en        = psel && penable && pwrite && addr_ok;
	assign rd_en        = psel && !penable && !pwrite;
	assign pslverr      = psel && penable && !addr_ok;

	// field decode
	assign comparator_power_on = comparator_control_one[ACMP_C1_ON];
	assign input_exchange      = comparator_control_one[ACMP_C1_EX];
	assign ref_level = comparator_control_one[ACMP_C1_REFH:ACMP_C1_REFL];
	assign input_pin_select = comparator_control_two[ACMP_C2_PSH:ACMP_C2_PSL];

	// reference steering; exchange moves the reference to the other terminal
	always_comb begin
		ref_ctl.ref_level    = ref_level;
		ref_ctl.ref_enable   = (ref_level != ACMP_REF_OFF);
		ref_ctl.minus_is_ref = ref_ctl.ref_enable
			&& (comparator_control_one[ACMP_C1_RSEL] ^ input_exchange);
		ref_ctl.plus_is_ref  = ref_ctl.ref_enable && !ref_ctl.minus_is_ref;
	end

	// pin buffers off by explicit bit or by being a selected input
	genvar gi;
	generate
		for (gi = 0; gi < ACMP_PINS; gi++) begin : g_pin
			if (gi < 5) begin : g_sel
				assign pin_buffer_disable[gi] = analog_port_disable[gi]
					| input_pin_select[gi];
			end else begin : g_plain
				assign pin_buffer_disable[gi] = analog_port_disable[gi];
			end
		end
	endgenerate

	// two-flop synchroniser on the analog result
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
		end else begin
			sync_a <= raw_compare;
			sync_b <= sync_a;
		end
	end

	// terminal swap inverts the comparison seen by software
	assign raw_oriented = sync_b ^ input_exchange;

	// majority-free filter: output follows only a settled history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			filt_hist  <= '0;
			filt_state <= 1'b0;
		end else begin
			filt_hist <= {filt_hist[ACMP_FILT_LEN-2:0], raw_oriented};
			if (&filt_hist) begin
				filt_state <= 1'b1;
			end else if (~|filt_hist) begin
				filt_state <= 1'b0;
			end
		end
	end

	always_comb begin
		if (!comparator_power_on) begin
			next_result = 1'b0;
		end else if (comparator_control_two[ACMP_C2_FILT]) begin
			next_result = filt_state;
		end else begin
			next_result = raw_oriented;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_q    <= 1'b0;
			result_prev <= 1'b0;
		end else begin
			result_q    <= next_result;
			result_prev <= result_q;
		end
	end

	assign compare_result      = result_q;
	assign timer_capture_input = result_q;

	// edge select: 0 rising, 1 falling
	assign edge_hit = comparator_control_one[ACMP_C1_IES]
		? (result_prev && !result_q) : (!result_prev && result_q);

	// control one: flag set wins over software or service clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comparator_control_one <= ACMP_RESET_BYTE;
		end else begin
			if (wr_en && (word_idx == {2'b00, ACMP_IDX_CTL1})) begin
				comparator_control_one <= pwdata[7:0];
			end else if (irq_serviced) begin
				comparator_control_one[ACMP_C1_FLAG] <= 1'b0;
			end
			if (edge_hit) begin
				comparator_control_one[ACMP_C1_FLAG] <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comparator_control_two <= ACMP_RESET_BYTE;
		end else if (wr_en && (word_idx == {2'b00, ACMP_IDX_CTL2})) begin
			comparator_control_two <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			analog_port_disable <= ACMP_RESET_BYTE;
		end else if (wr_en && (word_idx == {2'b00, ACMP_IDX_PDIS})) begin
			analog_port_disable <= pwdata[7:0];
		end
	end

	// sticky status: bit0 rising edge, bit1 falling edge; write one clears
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= ACMP_RESET_BYTE;
		end else begin
			for (int i = 0; i < 8; i++) begin
				if (wr_en && (word_idx == {2'b00, ACMP_IDX_IRQ_STAT}) && pwdata[i]) begin
					irq_status[i] <= 1'b0;
				end
			end
			if (!result_prev && result_q) begin
				irq_status[0] <= 1'b1;
			end
			if (result_prev && !result_q) begin
				irq_status[1] <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask <= ACMP_RESET_BYTE;
		end else if (wr_en && (word_idx == {2'b00, ACMP_IDX_IRQ_MASK})) begin
			irq_mask <= pwdata[7:0];
		end
	end

	assign compare_irq = comparator_control_one[ACMP_C1_FLAG]
		&& comparator_control_one[ACMP_C1_IE] && global_irq_enable;
	assign irq_out = |(irq_status & irq_mask);

	// read data registered in setup cycle, valid in access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= ACMP_ZERO_WORD;
		end else if (rd_en) begin
			prdata <= ACMP_ZERO_WORD;
			if (byte_aligned) begin
				unique case (word_idx)
					{2'b00, ACMP_IDX_CTL1}: prdata[7:0] <= comparator_control_one;
					{2'b00, ACMP_IDX_CTL2}: prdata[7:0] <= {comparator_control_two[7:1],
						result_q};
					{2'b00, ACMP_IDX_PDIS}: prdata[7:0] <= analog_port_disable;
					{2'b00, ACMP_IDX_IRQ_STAT}: prdata[7:0] <= irq_status;
					{2'b00, ACMP_IDX_IRQ_MASK}: prdata[7:0] <= irq_mask;
					default: prdata <= ACMP_ZERO_WORD;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ---- hdl/acmp_pkg.sv ----
// acmp_pkg: register map, field positions and carrier types for the comparator control block
// assumes an APB slave with byte registers in the low bits of aligned 32-bit words
package acmp_pkg;
	// printed offsets are not multiples of four: they are word indices
	localparam logic [7:0]  ACMP_IDX_CTL1     = 8'h59;
	localparam logic [7:0]  ACMP_IDX_CTL2     = 8'h5a;
	localparam logic [7:0]  ACMP_IDX_PDIS     = 8'h5b;
	localparam logic [7:0]  ACMP_IDX_IRQ_STAT = 8'h5c;
	localparam logic [7:0]  ACMP_IDX_IRQ_MASK = 8'h5d;
	localparam int          ACMP_ADDR_W       = 12;
	localparam logic [7:0]  ACMP_RESET_BYTE   = 8'h00;
	localparam logic [31:0] ACMP_ZERO_WORD    = 32'h0000_0000;
	// control one fields
	localparam int ACMP_C1_FLAG = 0;
	localparam int ACMP_C1_IE   = 1;
	localparam int ACMP_C1_IES  = 2;
	localparam int ACMP_C1_ON   = 3;
	localparam int ACMP_C1_REFL = 4;
	localparam int ACMP_C1_REFH = 5;
	localparam int ACMP_C1_RSEL = 6;
	localparam int ACMP_C1_EX   = 7;
	// control two fields
	localparam int ACMP_C2_RES  = 0;
	localparam int ACMP_C2_FILT = 1;
	localparam int ACMP_C2_PSL  = 2;
	localparam int ACMP_C2_PSH  = 6;
	localparam int ACMP_PINS    = 8;
	localparam int ACMP_FILT_LEN = 4;
	localparam logic [1:0] ACMP_REF_OFF     = 2'b00;
	localparam logic [1:0] ACMP_REF_QUARTER = 2'b01;
	localparam logic [1:0] ACMP_REF_HALF    = 2'b10;
	localparam logic [1:0] ACMP_REF_DIODE   = 2'b11;

	typedef struct packed {
		logic       plus_is_ref;
		logic       minus_is_ref;
		logic [1:0] ref_level;
		logic       ref_enable;
	} acmp_ref_ctl_t;
endpackage

// ---- testbench/acmp_analog_model.sv ----
// acmp_analog_model: analog levels on the comparator input pins
// assumes the bench sets both levels; ideal comparator stage
`timescale 1ns/10ps
`default_nettype none
module acmp_analog_model (
	input  var int plus_mv,
	input  var int minus_mv,
	output logic   raw_compare
);
	assign raw_compare = plus_mv > minus_mv;
endmodule
`default_nettype wire

// ---- testbench/acmp_control_chk.sv ----
// acmp_control_chk: port assertions for acmp_control
// assumes a bind onto acmp_control, one pclk domain
`timescale 1ns/10ps
`default_nettype none
module acmp_control_chk
	import acmp_pkg::*;
(
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic [ACMP_ADDR_W-1:0] paddr,
	input wire logic                   pready,
	input wire logic                   pslverr,
	input wire logic                   raw_compare,
	input wire logic                   global_irq_enable,
	input wire logic                   comparator_power_on,
	input wire logic                   input_exchange,
	input wire acmp_ref_ctl_t          ref_ctl,
	input wire logic                   compare_result,
	input wire logic                   timer_capture_input,
	input wire logic                   compare_irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_zero_wait:
	assert property (psel && penable |-> pready) else $error("wait state");
	a_unmapped_err:
	assert property (psel && penable |-> pslverr == (paddr[1:0] != 2'h0
		|| paddr[11:2] < 10'h059 || paddr[11:2] > 10'h05d)) else $error("bad slverr");
	a_power_off:
	assert property (!comparator_power_on && !$past(comparator_power_on) |-> !compare_result)
		else $error("result while off");
	a_capture_copy:
	assert property (timer_capture_input == compare_result) else $error("capture differs");
	a_ref_enable:
	assert property (ref_ctl.ref_enable == (ref_ctl.ref_level != 2'h0)) else $error("ref enable");
	a_ref_terminal:
	assert property (ref_ctl.ref_enable |-> ref_ctl.plus_is_ref != ref_ctl.minus_is_ref)
		else $error("ref terminal");
	a_result_cause:
	assert property ($rose(compare_result) |-> $past(raw_compare, 3) ^ input_exchange)
		else $error("result rose without cause");
	a_irq_global:
	assert property (compare_irq |-> global_irq_enable) else $error("request without enable");
endmodule
`default_nettype wire

// ---- testbench/acmp_control_tb_top.sv ----
// acmp_control_tb_top: self-checking bench for acmp_control
// assumes acmp_pkg compiled first; zero-wait APB slave
`timescale 1ns/10ps
`default_nettype none
module acmp_control_tb_top
	import acmp_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, raw_compare, err, t;
	logic global_irq_enable, irq_serviced, comparator_power_on, input_exchange;
	logic compare_result, timer_capture_input, compare_irq, irq_out;
	logic [ACMP_ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [ACMP_PINS-1:0] pin_buffer_disable;
	logic [7:0] v, c, p;
	acmp_ref_ctl_t ref_ctl;
	int plus_mv, minus_mv, n_fail = 0, samples_checked = 0;
	int m[5];
	acmp_control i_acmp_control (.*);
	acmp_analog_model i_acmp_analog_model (.*);
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic apb(logic w, logic [7:0] i, logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {2'h0, i, 2'h0};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (w && i > 8'h58 && i < 8'h5c) m[i - 8'h59] = d;
	endtask
	task automatic rc(logic [7:0] i, logic [31:0] e);
		apb(1'h0, i, 32'h0000_0000);
		chk("rdata", rd, e);
	endtask
	task automatic wt(int n);
		repeat (n) @(posedge pclk);
		@(negedge pclk);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		pclk = 1'h0;
		forever #10 pclk = ~pclk;
	end
	initial begin
		repeat (5000) @(posedge pclk);
		n_fail++;
		tally_and_finish();
	end
	initial begin
		{psel, penable, pwrite, presetn, global_irq_enable, irq_serviced} = 6'h00;
		paddr = '0;
		pwdata = '0;
		plus_mv = 0;
		minus_mv = 100;
		m = '{default: 0};
		void'($urandom(32'h1e00));
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		for (int i = 0; i < 5; i++) rc(8'h59 + i[7:0], 0);
		for (int k = 0; k < 8; k++) begin
			{v, c, p} = 24'($urandom);
			v &= 8'hf6;
			c &= 8'h7e;
			t = v[6] ^ v[7];
			apb(1'h1, ACMP_IDX_CTL1, v);
			apb(1'h1, ACMP_IDX_CTL2, c);
			apb(1'h1, ACMP_IDX_PDIS, p);
			wt(0);
			chk("level", ref_ctl.ref_level, v[5:4]);
			chk("refen", ref_ctl.ref_enable, v[5:4] != 2'h0);
			if (v[5:4] != 2'h0) chk("term", {ref_ctl.plus_is_ref, ref_ctl.minus_is_ref}, {~t, t});
			chk("swap", input_exchange, v[7]);
			chk("pins", pin_buffer_disable, p | {3'h0, c[6:2]});
			for (int i = 0; i < 3; i++) rc(8'h59 + i[7:0], m[i]);
		end
		rc(8'h00, 0);
		chk("slverr", err, 1'h1);
		apb(1'h1, ACMP_IDX_CTL2, 0);
		apb(1'h1, ACMP_IDX_PDIS, 0);
		apb(1'h1, ACMP_IDX_IRQ_MASK, 1);
		apb(1'h1, ACMP_IDX_CTL1, 8'h0a);
		@(posedge pclk) global_irq_enable <= 1'h1;
		@(posedge pclk) plus_mv <= 200;
		wt(6);
		chk("res", compare_result, 1'h1);
		chk("cap", timer_capture_input, 1'h1);
		chk("pwr", comparator_power_on, 1'h1);
		chk("req", compare_irq, 1'h1);
		chk("irq", irq_out, 1'h1);
		@(posedge pclk) global_irq_enable <= 1'h0;
		wt(0);
		chk("req", compare_irq, 1'h0);
		@(posedge pclk) irq_serviced <= 1'h1;
		@(posedge pclk) irq_serviced <= 1'h0;
		rc(ACMP_IDX_CTL1, 8'h0a);
		rc(ACMP_IDX_IRQ_STAT, 1);
		apb(1'h1, ACMP_IDX_IRQ_STAT, 1);
		wt(0);
		chk("irq", irq_out, 1'h0);
		apb(1'h1, ACMP_IDX_CTL1, 8'h0e);
		@(posedge pclk) plus_mv <= 0;
		wt(6);
		rc(ACMP_IDX_CTL1, 8'h0f);
		rc(ACMP_IDX_IRQ_STAT, 2);
		apb(1'h1, ACMP_IDX_CTL1, 8'h0e);
		rc(ACMP_IDX_CTL1, 8'h0e);
		apb(1'h1, ACMP_IDX_CTL1, 8'h88);
		wt(4);
		chk("res", compare_result, 1'h1);
		rc(ACMP_IDX_CTL2, 1);
		apb(1'h1, ACMP_IDX_CTL1, 8'h80);
		wt(3);
		chk("res", compare_result, 1'h0);
		// clear exchange first so the filter history settles low
		apb(1'h1, ACMP_IDX_CTL1, 8'h00);
		apb(1'h1, ACMP_IDX_CTL2, 2);
		apb(1'h1, ACMP_IDX_CTL1, 8'h08);
		@(posedge pclk) plus_mv <= 200;
		wt(3);
		chk("res", compare_result, 1'h0);
		wt(6);
		chk("res", compare_result, 1'h1);
		tally_and_finish();
	end
endmodule
bind acmp_control acmp_control_chk i_acmp_control_chk (.*);
`default_nettype wire
